/* logic/cvr_config_regs.sv */
// Sync, reference, input type, fuse load, pattern and frame clock registers
// Contract
// - Pin does power-down or sync per bit7
// - Trigger bit rise issues sync when enabled
// - Trigger bit never self-clears
// - Sync enable picks register over pin
// - Reference from pin or register field
// - Reference codes internal, buffered, direct
// - Single-ended clock only with bit3 set
// - Per-channel single-ended analog input bits
// - Fuse load bit loads output mapping
// - Pattern value from two bytes plus two
// - Ramp uses pattern value as step
// - Channel B pattern mode decode
// - Channel A pattern mode, same encoding
// - Patterns at full 18-bit width, live samples MSB aligned
// - Frame clock source converter or downconverter
// - Stretch bit widens frame clock
// - Mask decides blocks in global power-down
`default_nettype none
module cvr_config_regs
    import cvr_pkg::*;
#(
    parameter int NATIVE_W = 14,
    parameter int PAT_W = 18
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic spi_sclk,
    input wire logic spi_sen_n,
    input wire logic spi_sdi,
    output logic spi_sdo,
    input wire logic sync_powerdown_pin,
    input wire logic reference_buffer_pin,
    input wire logic [7:0] powerdown_mask,
    input wire logic [NATIVE_W-1:0] chan_a_sample,
    input wire logic [NATIVE_W-1:0] chan_b_sample,
    input wire logic sample_valid,
    output logic [PAT_W-1:0] chan_a_data,
    output logic [PAT_W-1:0] chan_b_data,
    output logic data_valid,
    output logic sync_pulse,
    output logic global_powerdown,
    output logic pd_clock_buffer,
    output logic pd_reference_amp,
    output logic pd_bandgap,
    output logic [1:0] reference_select,
    output logic single_ended_clock,
    output logic diff_clock_buffer_pd,
    output logic chan_a_single_ended,
    output logic chan_b_single_ended,
    output logic fuse_mapping_load_pulse,
    output logic frame_clock_source,
    output logic frame_clock_halving,
    output logic frame_clock_stretch
);

    cvr_spi_state_t spi_state_reg;
    logic sclk_reg;
    logic sclk_rise;
    logic sclk_fall;
    logic [4:0] bit_cnt_reg;
    logic [14:0] shift_reg;
    logic [7:0] rd_shift_reg;
    logic sdo_reg;
    logic wr_stb;
    logic [6:0] wr_addr;
    logic [7:0] wr_data;
    logic rd_load;
    logic [6:0] rd_addr;

    logic [7:0] sync_ref_reg;
    logic [7:0] ain_type_reg;
    logic [7:0] fuse_reg;
    logic [7:0] pat_low_reg;
    logic [7:0] pat_mid_reg;
    logic [7:0] pat_high_reg;
    logic [7:0] frame_clock_reg;

    logic pin_reg;
    logic trig_reg;
    logic fuse_prev_reg;
    logic sw_sync;
    logic pin_sync;
    logic pin_func_sync;
    logic sync_en;
    logic [PAT_W-1:0] user_pattern_value;

    // ========================================================
    // Register read decode; reserved and unmapped bits read zero
    function automatic logic [7:0] read_mux(input logic [6:0] addr);
        logic [7:0] val;
        val = 8'h00;
        unique case (addr)
            CVR_SYNC_REF_OFS: val = sync_ref_reg;
            CVR_AIN_TYPE_OFS: val = ain_type_reg;
            CVR_FUSE_OFS: val = fuse_reg;
            CVR_PAT_LOW_OFS: val = pat_low_reg;
            CVR_PAT_MID_OFS: val = pat_mid_reg;
            CVR_PAT_HIGH_OFS: val = pat_high_reg;
            CVR_FRAME_CLOCK_OFS: val = frame_clock_reg;
            default: val = 8'h00;
        endcase
        return val;
    endfunction

    // ========================================================
    // Serial control port
    assign sclk_rise = spi_sclk & ~sclk_reg;
    assign sclk_fall = ~spi_sclk & sclk_reg;
    assign wr_stb = (spi_state_reg == CVR_SHIFT) && sclk_rise &&
        (bit_cnt_reg == 5'(CVR_FRAME_BITS - 1)) && !shift_reg[14];
    assign wr_addr = shift_reg[13:7];
    assign wr_data = {shift_reg[6:0], spi_sdi};
    assign rd_load = (spi_state_reg == CVR_SHIFT) && sclk_rise &&
        (bit_cnt_reg == 5'(CVR_ADDR_PHASE_BITS - 1)) && shift_reg[6];
    assign rd_addr = {shift_reg[5:0], spi_sdi};
    assign spi_sdo = sdo_reg;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            sclk_reg <= 1'b0;
        end else begin
            sclk_reg <= spi_sclk;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            spi_state_reg <= CVR_IDLE;
            bit_cnt_reg <= CVR_CNT_RESET;
            shift_reg <= '0;
        end else if (spi_sen_n) begin
            // Deselect aborts any partial frame
            spi_state_reg <= CVR_IDLE;
            bit_cnt_reg <= CVR_CNT_RESET;
        end else begin
            unique case (spi_state_reg)
                CVR_IDLE: begin
                    spi_state_reg <= CVR_SHIFT;
                end
                CVR_SHIFT: begin
                    if (sclk_rise) begin
                        shift_reg <= {shift_reg[13:0], spi_sdi};
                        bit_cnt_reg <= bit_cnt_reg + 5'h01;
                        if (bit_cnt_reg == 5'(CVR_FRAME_BITS - 1)) begin
                            spi_state_reg <= CVR_DONE;
                        end
                    end
                end
                CVR_DONE: begin
                    spi_state_reg <= CVR_DONE;
                end
                default: begin
                    spi_state_reg <= CVR_IDLE;
                end
            endcase
        end
    end

    // Read data shifts out on falling edges, MSB first
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rd_shift_reg <= 8'h00;
            sdo_reg <= 1'b0;
        end else if (spi_sen_n) begin
            sdo_reg <= 1'b0;
        end else if (rd_load) begin
            rd_shift_reg <= read_mux(rd_addr);
        end else if (sclk_fall && spi_state_reg == CVR_SHIFT &&
            bit_cnt_reg >= 5'(CVR_ADDR_PHASE_BITS)) begin
            sdo_reg <= rd_shift_reg[7];
            rd_shift_reg <= {rd_shift_reg[6:0], 1'b0};
        end
    end

    // ========================================================
    // Register file; reserved bits are never stored
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            sync_ref_reg <= CVR_REG_RESET;
            ain_type_reg <= CVR_REG_RESET;
            fuse_reg <= CVR_REG_RESET;
            pat_low_reg <= CVR_REG_RESET;
            pat_mid_reg <= CVR_REG_RESET;
            pat_high_reg <= CVR_REG_RESET;
            frame_clock_reg <= CVR_REG_RESET;
        end else if (wr_stb) begin
            unique case (wr_addr)
                CVR_SYNC_REF_OFS: sync_ref_reg <=
                    wr_data & CVR_SYNC_REF_MASK;
                CVR_AIN_TYPE_OFS: ain_type_reg <=
                    wr_data & CVR_AIN_TYPE_MASK;
                CVR_FUSE_OFS: fuse_reg <= wr_data & CVR_FUSE_MASK;
                CVR_PAT_LOW_OFS: pat_low_reg <= wr_data;
                CVR_PAT_MID_OFS: pat_mid_reg <= wr_data;
                CVR_PAT_HIGH_OFS: pat_high_reg <= wr_data;
                CVR_FRAME_CLOCK_OFS: frame_clock_reg <= wr_data & CVR_FRAME_CLOCK_MASK;
                default: begin
                end
            endcase
        end
    end

    // ========================================================
    // Sync and power-down from pin and register
    assign sync_en = sync_ref_reg[CVR_SYNC_EN_BIT];
    assign pin_func_sync = sync_ref_reg[CVR_PIN_FUNC_BIT];
    assign sw_sync = sync_en & sync_ref_reg[CVR_SYNC_TRIG_BIT] &
        ~trig_reg;
    // Register sync replaces the pin as sync source
    assign pin_sync = pin_func_sync & ~sync_en & sync_powerdown_pin &
        ~pin_reg;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            pin_reg <= 1'b0;
            trig_reg <= 1'b0;
            sync_pulse <= 1'b0;
        end else begin
            pin_reg <= sync_powerdown_pin;
            trig_reg <= sync_ref_reg[CVR_SYNC_TRIG_BIT];
            sync_pulse <= sw_sync | pin_sync;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            global_powerdown <= 1'b0;
            pd_clock_buffer <= 1'b0;
            pd_reference_amp <= 1'b0;
            pd_bandgap <= 1'b0;
        end else begin
            global_powerdown <= ~pin_func_sync & sync_powerdown_pin;
            pd_clock_buffer <= ~pin_func_sync & sync_powerdown_pin &
                ~powerdown_mask[CVR_MASK_CLKBUF_BIT];
            pd_reference_amp <= ~pin_func_sync & sync_powerdown_pin &
                ~powerdown_mask[CVR_MASK_REFAMP_BIT];
            pd_bandgap <= ~pin_func_sync & sync_powerdown_pin &
                powerdown_mask[CVR_MASK_BG_BIT];
        end
    end

    // ========================================================
    // Reference and clock input choice
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            reference_select <= CVR_REF_INTERNAL;
        end else if (sync_ref_reg[CVR_REFERENCE_CONTROL_SOURCE_BIT]) begin
            reference_select <=
                sync_ref_reg[CVR_REF_SEL_HI:CVR_REF_SEL_LO];
        end else begin
            // Pin high means external reference through the buffer
            reference_select <= reference_buffer_pin ?
                CVR_REF_EXT_BUF : CVR_REF_INTERNAL;
        end
    end

    assign single_ended_clock = sync_ref_reg[CVR_REFERENCE_CONTROL_SOURCE_BIT] &
        sync_ref_reg[CVR_SE_CLK_BIT];
    assign diff_clock_buffer_pd = single_ended_clock;
    assign chan_a_single_ended = ain_type_reg[CVR_SE_A_BIT];
    assign chan_b_single_ended = ain_type_reg[CVR_SE_B_BIT];
    assign frame_clock_source = frame_clock_reg[CVR_FRAME_CLOCK_SOURCE_BIT];
    assign frame_clock_halving = frame_clock_reg[CVR_FRAME_CLOCK_HALF_BIT];
    assign frame_clock_stretch = frame_clock_reg[CVR_FRAME_CLOCK_STR_BIT];

    // ========================================================
    // Fuse mapping load strobe on each rise of the bit
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            fuse_prev_reg <= 1'b0;
            fuse_mapping_load_pulse <= 1'b0;
        end else begin
            fuse_prev_reg <= fuse_reg[CVR_FUSE_LD_BIT];
            fuse_mapping_load_pulse <= fuse_reg[CVR_FUSE_LD_BIT] &
                ~fuse_prev_reg;
        end
    end

    // ========================================================
    // Test pattern generators
    assign user_pattern_value = {pat_high_reg[CVR_PAT_TOP_HI:0],
        pat_mid_reg, pat_low_reg};

    cvr_pattern_gen #(
        .NATIVE_W(NATIVE_W),
        .PAT_W(PAT_W)
    ) u_pat_a (
        .mclk(mclk),
        .rst(rst),
        .mode(pat_high_reg[CVR_PAT_A_HI:CVR_PAT_A_LO]),
        .pattern(user_pattern_value),
        .sample(chan_a_sample),
        .sample_valid(sample_valid),
        .out_data(chan_a_data),
        .out_valid(data_valid)
    );

    cvr_pattern_gen #(
        .NATIVE_W(NATIVE_W),
        .PAT_W(PAT_W)
    ) u_pat_b (
        .mclk(mclk),
        .rst(rst),
        .mode(pat_high_reg[CVR_PAT_B_HI:CVR_PAT_B_LO]),
        .pattern(user_pattern_value),
        .sample(chan_b_sample),
        .sample_valid(sample_valid),
        .out_data(chan_b_data),
        .out_valid()
    );

    // ========================================================
    // Checks
    sequence trig_rise_s;
        sync_en && sync_ref_reg[CVR_SYNC_TRIG_BIT] && !trig_reg;
    endsequence

    sequence one_pulse_s;
        sync_pulse ##1 !sync_pulse;
    endsequence

    sw_sync_pulse_a: assert property (@(posedge mclk) disable iff (rst)
        trig_rise_s |=> one_pulse_s)
        else $error("software sync pulse missing or long");

    pin_powerdown_a: assert property (@(posedge mclk) disable iff (rst)
        (!pin_func_sync && sync_powerdown_pin) |=> global_powerdown)
        else $error("pin did not power down");

    pin_blocked_a: assert property (@(posedge mclk) disable iff (rst)
        (sync_en && !sync_ref_reg[CVR_SYNC_TRIG_BIT]) |=> !sync_pulse)
        else $error("pin sync leaked past register enable");

    trig_hold_a: assert property (@(posedge mclk) disable iff (rst)
        !wr_stb |=> $stable(sync_ref_reg[CVR_SYNC_TRIG_BIT]))
        else $error("sync trigger bit changed without write");

    ref_pin_a: assert property (@(posedge mclk) disable iff (rst)
        !sync_ref_reg[CVR_REFERENCE_CONTROL_SOURCE_BIT]
        |=> reference_select[1] == 1'b0)
        else $error("reference field used while pin controls");

    se_clock_a: assert property (@(posedge mclk) disable iff (rst)
        !sync_ref_reg[CVR_REFERENCE_CONTROL_SOURCE_BIT] |-> !diff_clock_buffer_pd)
        else $error("clock buffer off without register control");

    fuse_strobe_a: assert property (@(posedge mclk) disable iff (rst)
        $rose(fuse_reg[CVR_FUSE_LD_BIT])
        |=> fuse_mapping_load_pulse ##1 !fuse_mapping_load_pulse)
        else $error("fuse load strobe wrong");

    reserved_zero_a: assert property (@(posedge mclk) disable iff (rst)
        (sync_ref_reg[4] == 1'b0) && (frame_clock_reg[6:5] == 2'h0) &&
        (ain_type_reg[3:0] == 4'h0))
        else $error("reserved bit stored");

    clkbuf_mask_a: assert property (@(posedge mclk) disable iff (rst)
        powerdown_mask[CVR_MASK_CLKBUF_BIT] && $stable(powerdown_mask)
        |-> !pd_clock_buffer || !$past(powerdown_mask[3]))
        else $error("masked clock buffer powered down");

endmodule
`default_nettype wire

/* logic/cvr_pattern_gen.sv */
// Per-channel test-pattern insertion ahead of the output bit mapper
`default_nettype none
module cvr_pattern_gen
    import cvr_pkg::*;
#(
    parameter int NATIVE_W = 14,
    parameter int PAT_W = 18
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [2:0] mode,
    input wire logic [PAT_W-1:0] pattern,
    input wire logic [NATIVE_W-1:0] sample,
    input wire logic sample_valid,
    output logic [PAT_W-1:0] out_data,
    output logic out_valid
);

    logic [PAT_W-1:0] ramp_reg;
    logic [PAT_W-1:0] ramp_next;

    // ========================================================
    // Ramp accumulator
    assign ramp_next = ramp_reg + pattern;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ramp_reg <= '0;
        end else if (mode != CVR_PAT_RAMP) begin
            ramp_reg <= '0;
        end else if (sample_valid) begin
            ramp_reg <= ramp_next;
        end
    end

    // ========================================================
    // Output select, MSB-aligned native samples
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            out_data <= '0;
            out_valid <= 1'b0;
        end else begin
            out_valid <= sample_valid;
            if (sample_valid) begin
                unique case (mode)
                    CVR_PAT_RAMP: out_data <= ramp_reg;
                    CVR_PAT_CONST: out_data <= pattern;
                    // Unused codes fall back to live data
                    default: out_data <= {sample,
                        {(PAT_W-NATIVE_W){1'b0}}};
                endcase
            end
        end
    end

    // ========================================================
    // Checks
    const_mode_a: assert property (@(posedge mclk) disable iff (rst)
        (sample_valid && mode == CVR_PAT_CONST)
        |=> out_data == $past(pattern))
        else $error("constant pattern not driven");

    normal_mode_a: assert property (@(posedge mclk) disable iff (rst)
        (sample_valid && mode == CVR_PAT_NORMAL)
        |=> out_data[PAT_W-1 -: NATIVE_W] == $past(sample))
        else $error("normal sample not msb aligned");

    ramp_step_a: assert property (@(posedge mclk) disable iff (rst)
        (sample_valid && mode == CVR_PAT_RAMP) ##1
        (sample_valid && mode == CVR_PAT_RAMP)
        |=> out_data == $past(out_data) + $past(pattern, 2))
        else $error("ramp did not advance by the step");

endmodule
`default_nettype wire

/* logic/cvr_pkg.sv */
// Package of offsets, field positions and constants for the config bank
`default_nettype none
package cvr_pkg;

    // ========================================================
    // Register offsets
    localparam logic [6:0] CVR_SYNC_REF_OFS = 7'h0e;
    localparam logic [6:0] CVR_AIN_TYPE_OFS = 7'h11;
    localparam logic [6:0] CVR_FUSE_OFS = 7'h13;
    localparam logic [6:0] CVR_PAT_LOW_OFS = 7'h14;
    localparam logic [6:0] CVR_PAT_MID_OFS = 7'h15;
    localparam logic [6:0] CVR_PAT_HIGH_OFS = 7'h16;
    localparam logic [6:0] CVR_FRAME_CLOCK_OFS = 7'h19;

    // ========================================================
    // Reset values and writable-bit masks
    localparam logic [7:0] CVR_REG_RESET = 8'h00;
    localparam logic [7:0] CVR_SYNC_REF_MASK = 8'hef;
    localparam logic [7:0] CVR_AIN_TYPE_MASK = 8'h30;
    localparam logic [7:0] CVR_FUSE_MASK = 8'h01;
    localparam logic [7:0] CVR_FULL_MASK = 8'hff;
    localparam logic [7:0] CVR_FRAME_CLOCK_MASK = 8'h91;

    // ========================================================
    // Field positions
    localparam int CVR_PIN_FUNC_BIT = 7;
    localparam int CVR_SYNC_TRIG_BIT = 6;
    localparam int CVR_SYNC_EN_BIT = 5;
    localparam int CVR_REFERENCE_CONTROL_SOURCE_BIT = 3;
    localparam int CVR_REF_SEL_HI = 2;
    localparam int CVR_REF_SEL_LO = 1;
    localparam int CVR_SE_CLK_BIT = 0;
    localparam int CVR_SE_A_BIT = 5;
    localparam int CVR_SE_B_BIT = 4;
    localparam int CVR_FUSE_LD_BIT = 0;
    localparam int CVR_PAT_B_HI = 7;
    localparam int CVR_PAT_B_LO = 5;
    localparam int CVR_PAT_A_HI = 4;
    localparam int CVR_PAT_A_LO = 2;
    localparam int CVR_PAT_TOP_HI = 1;
    localparam int CVR_FRAME_CLOCK_SOURCE_BIT = 7;
    localparam int CVR_FRAME_CLOCK_HALF_BIT = 4;
    localparam int CVR_FRAME_CLOCK_STR_BIT = 0;
    localparam int CVR_MASK_CLKBUF_BIT = 3;
    localparam int CVR_MASK_REFAMP_BIT = 2;
    localparam int CVR_MASK_BG_BIT = 1;

    // ========================================================
    // Reference choices and pattern modes
    localparam logic [1:0] CVR_REF_INTERNAL = 2'h0;
    localparam logic [1:0] CVR_REF_EXT_BUF = 2'h1;
    localparam logic [1:0] CVR_REF_EXT_DIRECT = 2'h2;
    localparam logic [2:0] CVR_PAT_NORMAL = 3'h0;
    localparam logic [2:0] CVR_PAT_RAMP = 3'h2;
    localparam logic [2:0] CVR_PAT_CONST = 3'h3;

    // ========================================================
    // Serial frame: read flag, 7-bit address, 8-bit data
    localparam int CVR_FRAME_BITS = 16;
    localparam int CVR_ADDR_PHASE_BITS = 8;
    localparam logic [4:0] CVR_CNT_RESET = 5'h00;

    typedef enum logic [1:0] {
        CVR_IDLE = 2'b00,
        CVR_SHIFT = 2'b01,
        CVR_DONE = 2'b11
    } cvr_spi_state_t;

endpackage
`default_nettype wire

/* tb/cvr_host_model.sv */
// Host model that drives the serial configuration port of the bank
`default_nettype none
module cvr_host_model (
    input wire logic mclk,
    output logic spi_sclk,
    output logic spi_sen_n,
    output logic spi_sdi,
    input wire logic spi_sdo
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        spi_sclk = 1'b0;
        spi_sen_n = 1'b1;
        spi_sdi = 1'b0;
    end

    // ====
    // One frame; each clock level held 3 mclk, slow enough for the sampler
    task automatic xfer(input logic rd, input logic [6:0] a,
                        input logic [7:0] d, output logic [7:0] q);
        logic [15:0] f;
        f = {rd, a, d};
        q = 8'h00;
        @(negedge mclk) spi_sen_n = 1'b0;
        for (int i = 15; i >= 0; i--) begin
            spi_sdi = f[i];
            repeat (3) @(negedge mclk);
            if (i < 8) q[i] = spi_sdo;
            spi_sclk = 1'b1;
            repeat (3) @(negedge mclk);
            spi_sclk = 1'b0;
        end
        repeat (3) @(negedge mclk);
        spi_sen_n = 1'b1;
        // Released line must not keep showing its last bit
        spi_sdi = ~spi_sdi;
        repeat (3) @(negedge mclk);
    endtask
endmodule
`default_nettype wire

/* tb/tb.sv */
// Self-checking bench for the configuration register bank
`default_nettype none
module tb import cvr_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk, rst, sclk, sen_n, sdi, sdo, pin, refpin, sval, dval;
    logic syncp, gpd, pdc, pdr, pdb, seclk, dpd, sea, seb, fusep;
    logic fsrc, fhalf, fstr;
    logic [1:0] rsel;
    logic [7:0] mask, q;
    logic [13:0] sa, sb;
    logic [17:0] da, db, prev;
    int n_errors = 0;
    int comparisons = 0;
    int n_sync = 0;
    int n_fuse = 0;
    int s;
    logic [6:0] ofs [7] = '{CVR_SYNC_REF_OFS, CVR_AIN_TYPE_OFS,
        CVR_FUSE_OFS, CVR_PAT_LOW_OFS, CVR_PAT_MID_OFS, CVR_PAT_HIGH_OFS,
        CVR_FRAME_CLOCK_OFS};
    logic [7:0] msk [7] = '{CVR_SYNC_REF_MASK, CVR_AIN_TYPE_MASK,
        CVR_FUSE_MASK, CVR_FULL_MASK, CVR_FULL_MASK, CVR_FULL_MASK,
        CVR_FRAME_CLOCK_MASK};

    cvr_config_regs cvr_config_regs_inst (.mclk(mclk), .rst(rst),
        .spi_sclk(sclk), .spi_sen_n(sen_n), .spi_sdi(sdi), .spi_sdo(sdo),
        .sync_powerdown_pin(pin), .reference_buffer_pin(refpin),
        .powerdown_mask(mask), .chan_a_sample(sa), .chan_b_sample(sb),
        .sample_valid(sval), .chan_a_data(da), .chan_b_data(db),
        .data_valid(dval), .sync_pulse(syncp), .global_powerdown(gpd),
        .pd_clock_buffer(pdc), .pd_reference_amp(pdr), .pd_bandgap(pdb),
        .reference_select(rsel), .single_ended_clock(seclk),
        .diff_clock_buffer_pd(dpd), .chan_a_single_ended(sea),
        .chan_b_single_ended(seb), .fuse_mapping_load_pulse(fusep),
        .frame_clock_source(fsrc), .frame_clock_halving(fhalf),
        .frame_clock_stretch(fstr));
    cvr_host_model cvr_host_model_inst (.mclk(mclk), .spi_sclk(sclk),
        .spi_sen_n(sen_n), .spi_sdi(sdi), .spi_sdo(sdo));

    initial mclk = 1'b0;
    always #10 mclk = ~mclk;
    // Count pulses away from the edge that launches them
    always @(negedge mclk) begin
        if (syncp === 1'b1) n_sync++;
        if (fusep === 1'b1) n_fuse++;
    end

    // ====
    // Shared tasks
    task automatic chk(input logic [17:0] g, input logic [17:0] e);
        comparisons++;
        if (g !== e) begin
            n_errors++;
            $display("unexpected at %0t: got %h exp %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        cvr_host_model_inst.xfer(1'b0, a, d, q);
    endtask
    task automatic rd(input logic [6:0] a, input logic [7:0] e);
        cvr_host_model_inst.xfer(1'b1, a, 8'h00, q);
        chk(18'(q), 18'(e));
    endtask
    task automatic smp(input int n);
        @(negedge mclk) sval = 1'b1;
        repeat (n) @(negedge mclk);
        sval = 1'b0;
        chk(18'(dval), 18'h1);
    endtask
    task automatic done(input string t);
        $display("test %s finished", t);
    endtask
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Hang guard
    initial begin
        #1000000;
        n_errors++;
        wrap_up();
    end

    // ====
    // Main sequence
    initial begin
        rst = 1'b1;
        pin = 1'b0;
        refpin = 1'b0;
        sval = 1'b0;
        mask = 8'h00;
        sa = 14'h1c3d;
        sb = 14'h2a5b;
        repeat (3) @(negedge mclk);
        rst = 1'b0;
        foreach (ofs[i]) rd(ofs[i], 8'h00);
        foreach (ofs[i]) begin
            wr(ofs[i], 8'hff);
            rd(ofs[i], msk[i]);
        end
        chk(18'({fsrc, fhalf, fstr, sea, seb, seclk, dpd}), 18'h7f);
        wr(7'h12, 8'hff);
        rd(7'h12, 8'h00);
        foreach (ofs[i]) wr(ofs[i], 8'h00);
        wr(CVR_AIN_TYPE_OFS, 8'h20);
        chk(18'({sea, seb}), 18'h2);
        wr(CVR_FRAME_CLOCK_OFS, 8'h10);
        chk(18'({fsrc, fhalf, fstr}), 18'h2);
        done("registers");

        refpin = 1'b1;
        wr(CVR_SYNC_REF_OFS, 8'h00);
        chk(18'(rsel), 18'h1);
        for (int c = 0; c < 3; c++) begin
            wr(CVR_SYNC_REF_OFS, 8'(8 + 2 * c));
            chk(18'(rsel), 18'(c));
        end
        wr(CVR_SYNC_REF_OFS, 8'h01);
        chk(18'({seclk, dpd}), 18'h0);
        wr(CVR_SYNC_REF_OFS, 8'h09);
        chk(18'({seclk, dpd}), 18'h3);
        done("reference");

        wr(CVR_SYNC_REF_OFS, 8'h20);
        s = n_sync;
        wr(CVR_SYNC_REF_OFS, 8'h60);
        chk(18'(n_sync - s), 18'h1);
        wr(CVR_SYNC_REF_OFS, 8'h60);
        rd(CVR_SYNC_REF_OFS, 8'h60);
        wr(CVR_SYNC_REF_OFS, 8'h20);
        wr(CVR_SYNC_REF_OFS, 8'h60);
        chk(18'(n_sync - s), 18'h2);
        wr(CVR_SYNC_REF_OFS, 8'h00);
        wr(CVR_SYNC_REF_OFS, 8'h40);
        chk(18'(n_sync - s), 18'h2);
        wr(CVR_SYNC_REF_OFS, 8'h00);
        pin = 1'b1;
        repeat (3) @(negedge mclk);
        chk(18'({gpd, pdc, pdr, pdb}), 18'he);
        mask = 8'h0e;
        repeat (3) @(negedge mclk);
        chk(18'({gpd, pdc, pdr, pdb}), 18'h9);
        pin = 1'b0;
        wr(CVR_SYNC_REF_OFS, 8'h80);
        pin = 1'b1;
        repeat (4) @(negedge mclk);
        chk(18'({gpd, 2'(n_sync - s)}), 18'h3);
        pin = 1'b0;
        wr(CVR_SYNC_REF_OFS, 8'ha0);
        pin = 1'b1;
        repeat (4) @(negedge mclk);
        chk(18'(n_sync - s), 18'h3);
        pin = 1'b0;
        done("sync");

        s = n_fuse;
        wr(CVR_FUSE_OFS, 8'h01);
        wr(CVR_FUSE_OFS, 8'h01);
        chk(18'(n_fuse - s), 18'h1);
        done("fuse");

        wr(CVR_PAT_LOW_OFS, 8'h10);
        wr(CVR_PAT_MID_OFS, 8'h00);
        wr(CVR_PAT_HIGH_OFS, 8'h6a);
        smp(1);
        chk(db, 18'h20010);
        // Back to the 14-bit increment before timing the ramp
        wr(CVR_PAT_HIGH_OFS, 8'h68);
        smp(1);
        prev = da;
        smp(2);
        chk(da - prev, 18'h20);
        for (int c = 0; c < 8; c++) begin
            wr(CVR_PAT_HIGH_OFS, 8'((c << 5) | (c << 2)));
            smp(1);
            chk(db, (c == 2) ? 18'h0 :
                (c == 3) ? 18'h10 : {sb, 4'h0});
            chk(da, (c == 2) ? 18'h0 :
                (c == 3) ? 18'h10 : {sa, 4'h0});
        end
        done("patterns");
        wrap_up();
    end
endmodule
`default_nettype wire
